// ### design/usr_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Head entry is visible on out_data while out_valid is high.
module usr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH),
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [LW-1:0]    level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [LW-1:0]    cnt_q, cnt_d;
  logic             do_wr, do_rd;

  assign in_ready  = (cnt_q != LW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign level     = cnt_q;

  always_comb
  begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    // Wrap explicitly so a depth that is not a power of two still works
    if (do_wr)
    begin
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : AW'(wp_q + 1'b1);
    end
    if (do_rd)
    begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : AW'(rp_q + 1'b1);
    end
    if (do_wr && !do_rd)
    begin
      cnt_d = LW'(cnt_q + 1'b1);
    end
    else if (do_rd && !do_wr)
    begin
      cnt_d = LW'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wp_q] <= in_data;
    end
  end

endmodule

// ### design/usr_status.sv
// Purpose: Serial receiver with error-counting status register.
// Assumes: rxd is asynchronous; standby and tx events are on clk.
// Notes:   Registers reached over AXI4-Lite, one aligned word each.
//
// Register access over AXI4-Lite and the address map were decided locally.
module usr_status #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          rxd,
  input  wire logic          standby,
  input  wire logic          tx_end_evt,
  input  wire logic          tx_fifo_empty_evt,
  input  wire usr_pkg::usr_axi_req_t axi_req,
  output usr_pkg::usr_axi_rsp_t      axi_rsp
);
  import usr_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH + 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  usr_axi_rsp_t  rsp_q, rsp_d;
  logic [7:0]    waddr_q, waddr_d;
  logic [31:0]   wdata_q, wdata_d;
  logic [3:0]    wstrb_q, wstrb_d;
  logic          wr_go, rd_go, rd_status, wr_status, pop;
  logic [31:0]   rd_mux;
  logic          rd_hit, wr_hit;
  logic          rx_en_q, rx_en_d;
  logic [7:0]    mode_q, mode_d;
  logic [15:0]   baud_q, baud_d;
  logic [7:0]    flags_q, flags_d, armed_q, armed_d, set_v;
  logic [LW-1:0] pcnt_q, pcnt_d, fcnt_q, fcnt_d, level;
  logic [3:0]    pcnt_v, fcnt_v;
  logic [15:0]   status_v;
  logic          rxd_s1, rxd_s2, rxd_s3, rxd_v_q, rxd_v_d;
  usr_rx_state_t st_q, st_d;
  logic [15:0]   tmr_q, tmr_d;
  logic [3:0]    bitn_q, bitn_d;
  logic [7:0]    shr_q, shr_d;
  logic          pbit_q, pbit_d;
  logic          push, push_ok, in_ready, head_valid;
  usr_entry_t    entry, head;
  logic          er_set, brk_set, ovr_set;
  logic          par_en, par_odd, two_stop;

  assign axi_rsp  = rsp_q;
  assign par_en   = mode_q[B_PAR_EN];
  assign par_odd  = mode_q[B_PAR_ODD];
  assign two_stop = mode_q[B_TWO_STOP];

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  usr_fifo #(
    .WIDTH ($bits(usr_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (entry),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head),
    .level     (level)
  );

  // ----------------------------------------------------------------
  // Status view
  // ----------------------------------------------------------------
  // Counters can reach the FIFO depth; the 4-bit fields saturate.
  assign pcnt_v   = (pcnt_q > LW'(CNT_MAX)) ? CNT_MAX : pcnt_q[CNT_W-1:0];
  assign fcnt_v   = (fcnt_q > LW'(CNT_MAX)) ? CNT_MAX : fcnt_q[CNT_W-1:0];
  assign status_v = {pcnt_v, fcnt_v, flags_q[7:4],
                     head_valid && head.framing_error_bit,
                     head_valid && head.parity_error_bit, flags_q[1:0]};

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = '0;
    case (axi_req.araddr)
      OFF_STATUS: rd_mux = {16'h0000, status_v};
      OFF_RXDATA: rd_mux = {24'h000000, head_valid ? head.data : 8'h00};
      OFF_CTRL:   rd_mux = {27'h0000000, rx_en_q, 4'h0};
      OFF_MODE:   rd_mux = {24'h000000, mode_q};
      OFF_BAUD:   rd_mux = {16'h0000, baud_q};
      default:    rd_hit = 1'b0;
    endcase
    wr_hit = (waddr_q == OFF_STATUS) || (waddr_q == OFF_RXDATA) ||
             (waddr_q == OFF_CTRL) || (waddr_q == OFF_MODE) ||
             (waddr_q == OFF_BAUD);
  end

  always_comb
  begin
    rsp_d   = rsp_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    wr_go   = 1'b0;
    rd_go   = 1'b0;
    if (rsp_q.awready && axi_req.awvalid)
    begin
      waddr_d       = axi_req.awaddr;
      rsp_d.awready = 1'b0;
    end
    if (rsp_q.wready && axi_req.wvalid)
    begin
      wdata_d      = axi_req.wdata;
      wstrb_d      = axi_req.wstrb;
      rsp_d.wready = 1'b0;
    end
    // Both halves held: perform the write and answer
    if (!rsp_q.awready && !rsp_q.wready && !rsp_q.bvalid)
    begin
      wr_go        = 1'b1;
      rsp_d.bvalid = 1'b1;
      rsp_d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rsp_q.bvalid && axi_req.bready)
    begin
      rsp_d.bvalid  = 1'b0;
      rsp_d.awready = 1'b1;
      rsp_d.wready  = 1'b1;
    end
    if (rsp_q.arready && axi_req.arvalid)
    begin
      rd_go         = 1'b1;
      rsp_d.arready = 1'b0;
      rsp_d.rvalid  = 1'b1;
      rsp_d.rdata   = rd_mux;
      rsp_d.rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rsp_q.rvalid && axi_req.rready)
    begin
      rsp_d.rvalid  = 1'b0;
      rsp_d.arready = 1'b1;
    end
  end

  assign rd_status = rd_go && (axi_req.araddr == OFF_STATUS);
  assign wr_status = wr_go && (waddr_q == OFF_STATUS) && wstrb_q[0];
  assign pop       = rd_go && (axi_req.araddr == OFF_RXDATA) && head_valid;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rsp_q         <= '0;
      rsp_q.awready <= 1'b1;
      rsp_q.wready  <= 1'b1;
      rsp_q.arready <= 1'b1;
      waddr_q       <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end
    else
    begin
      rsp_q   <= rsp_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and status flags
  // ----------------------------------------------------------------
  always_comb
  begin
    rx_en_d = rx_en_q;
    mode_d  = mode_q;
    baud_d  = baud_q;
    flags_d = flags_q;
    armed_d = armed_q;
    if (wr_go && wstrb_q[0])
    begin
      if (waddr_q == OFF_CTRL)
        rx_en_d = wdata_q[B_RXEN];
      if (waddr_q == OFF_MODE)
        mode_d = wdata_q[7:0];
      if (waddr_q == OFF_BAUD)
        baud_d[7:0] = wdata_q[7:0];
    end
    if (wr_go && wstrb_q[1] && (waddr_q == OFF_BAUD))
      baud_d[15:8] = wdata_q[15:8];
    // A read remembers which flags were seen as 1
    if (rd_status)
      armed_d = armed_q | (flags_q & STICKY_MASK);
    for (int i = 0; i < 8; i++)
    begin
      // Written 1s are ignored; 0 clears only an armed flag
      if (wr_status && STICKY_MASK[i] && !wdata_q[i])
      begin
        if (armed_q[i])
          flags_d[i] = 1'b0;
        armed_d[i] = 1'b0;
      end
    end
    // Set wins over a written clear in the same cycle; standby still clears ER
    flags_d = flags_d | (set_v & STICKY_MASK);
    if (standby)
    begin
      flags_d[B_ER]   = 1'b0;
      armed_d[B_ER]   = 1'b0;
      flags_d[B_TX_END_FLAG] = 1'b1;
      flags_d[B_TX_FIFO_EMPTY_FLAG] = 1'b1;
    end
  end

  assign set_v = {er_set, tx_end_evt, tx_fifo_empty_evt, brk_set,
                  2'h0, ovr_set, push_ok};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_en_q <= 1'b0;
      mode_q  <= '0;
      baud_q  <= BAUD_RST;
      flags_q <= FLAGS_RST;
      armed_q <= '0;
    end
    else
    begin
      rx_en_q <= rx_en_d;
      mode_q  <= mode_d;
      baud_q  <= baud_d;
      flags_q <= flags_d;
      armed_q <= armed_d;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    tmr_d   = (tmr_q == '0) ? tmr_q : 16'(tmr_q - 1'b1);
    bitn_d  = bitn_q;
    shr_d   = shr_q;
    pbit_d  = pbit_q;
    rxd_v_d = (rxd_s2 == rxd_s3) ? rxd_s3 : rxd_v_q;
    push    = 1'b0;
    entry   = '0;
    entry.data = shr_q;
    case (st_q)
      RX_IDLE:
        if (rx_en_q && !rxd_v_q)
        begin
          st_d  = RX_START;
          tmr_d = baud_q >> 1;
        end
      RX_START:
        if (tmr_q == '0)
        begin
          st_d   = rxd_v_q ? RX_IDLE : RX_DATA;
          tmr_d  = 16'(baud_q - 1'b1);
          bitn_d = '0;
        end
      RX_DATA:
        if (tmr_q == '0)
        begin
          shr_d  = {rxd_v_q, shr_q[7:1]};
          bitn_d = 4'(bitn_q + 1'b1);
          tmr_d  = 16'(baud_q - 1'b1);
          if (bitn_q == 4'(CHAR_BITS - 1))
            st_d = par_en ? RX_PAR : RX_STOP1;
        end
      RX_PAR:
        if (tmr_q == '0)
        begin
          pbit_d = rxd_v_q;
          tmr_d  = 16'(baud_q - 1'b1);
          st_d   = RX_STOP1;
        end
      RX_STOP1:
        if (tmr_q == '0)
        begin
          // Errored characters are stored like any other
          push      = 1'b1;
          entry.framing_error_bit = !rxd_v_q;
          entry.parity_error_bit = par_en && ((^{shr_q, pbit_q}) != par_odd);
          tmr_d     = 16'(baud_q - 1'b1);
          st_d      = two_stop ? RX_STOP2 : RX_IDLE;
        end
      RX_STOP2:
        // Second stop bit is only timed, never sampled
        if (tmr_q == '0)
          st_d = RX_IDLE;
      default:
        st_d = RX_IDLE;
    endcase
    if (!rx_en_q || standby)
      st_d = RX_IDLE;
  end

  assign push_ok = push && in_ready;
  assign ovr_set = push && !in_ready;
  assign er_set  = push && (entry.framing_error_bit || entry.parity_error_bit);
  assign brk_set = push && entry.framing_error_bit && (shr_q == 8'h00);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxd_s1  <= 1'b1;
      rxd_s2  <= 1'b1;
      rxd_s3  <= 1'b1;
      rxd_v_q <= 1'b1;
      st_q    <= RX_IDLE;
      tmr_q   <= '0;
      bitn_q  <= '0;
      shr_q   <= '0;
      pbit_q  <= 1'b0;
    end
    else
    begin
      rxd_s1  <= rxd;
      rxd_s2  <= rxd_s1;
      rxd_s3  <= rxd_s2;
      rxd_v_q <= rxd_v_d;
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      bitn_q  <= bitn_d;
      shr_q   <= shr_d;
      pbit_q  <= pbit_d;
    end
  end

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  always_comb
  begin
    pcnt_d = LW'(pcnt_q + (push_ok && entry.parity_error_bit)
                        - (pop && head.parity_error_bit));
    fcnt_d = LW'(fcnt_q + (push_ok && entry.framing_error_bit)
                        - (pop && head.framing_error_bit));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pcnt_q <= '0;
      fcnt_q <= '0;
    end
    else
    begin
      pcnt_q <= pcnt_d;
      fcnt_q <= fcnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_flag_hw_set: assert property ($rose(flags_q[B_ER]) |->
      $past(er_set))
    else $error("receive error flag rose without an error event");
  a_clear_armed: assert property ($fell(flags_q[B_ER]) |->
      $past(armed_q[B_ER] && wr_status) || $past(standby))
    else $error("receive error flag cleared without prior read");
  a_head_bits: assert property (rsp_q.rvalid && $past(rd_status)
      |-> rsp_q.rdata[B_FER] == $past(head_valid && head.framing_error_bit))
    else $error("framing bit does not match FIFO head");
  a_per_count: assert property (pcnt_q <= level)
    else $error("parity error count exceeds FIFO level");
  a_fer_count: assert property (fcnt_q <= level &&
      fcnt_q <= LW'(FIFO_DEPTH))
    else $error("framing error count exceeds FIFO level");
  a_stop_err: assert property (push && entry.framing_error_bit && !standby |=>
      flags_q[B_ER])
    else $error("bad stop bit did not set receive error");
  a_parity_err: assert property (push && par_en && entry.parity_error_bit &&
      !standby |=> flags_q[B_ER])
    else $error("parity mismatch did not set receive error");
  a_two_stop: assert property (st_q == RX_STOP2 |-> !push)
    else $error("second stop bit produced a character");
  a_standby_clr: assert property (standby |=> !flags_q[B_ER] ##1
      (flags_q[B_ER] == $past(er_set && !standby)))
    else $error("standby did not clear receive error");
  // The flag may still take a set or standby from the disabling cycle
  a_rxen_keeps: assert property ($fell(rx_en_q) &&
      !$past(er_set || standby) |-> flags_q[B_ER] == $past(flags_q[B_ER]))
    else $error("receiver disable changed receive error");
  a_err_stored: assert property (push && in_ready && entry.framing_error_bit |=>
      fcnt_q == LW'($past(fcnt_q) + 1'b1 - $past(pop && head.framing_error_bit)))
    else $error("framing error character not stored");
  a_rx_gate: assert property (st_q == RX_IDLE && !rx_en_q |=>
      st_q == RX_IDLE)
    else $error("receiver left idle while disabled");

endmodule

// ### include/usr_pkg.sv
// Purpose: Shared constants and types for the serial receive status block.
// Assumes: AXI4-Lite slave, 32-bit data, 8-bit byte addresses.
// Notes:   Register offsets and mode bits below are local choices.
package usr_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_RXDATA  = 8'h04;
  localparam logic [7:0] OFF_CTRL    = 8'h08;
  localparam logic [7:0] OFF_MODE    = 8'h0C;
  localparam logic [7:0] OFF_BAUD    = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int         B_ER        = 7;
  localparam int         B_TX_END_FLAG      = 6;
  localparam int         B_TX_FIFO_EMPTY_FLAG      = 5;
  localparam int         B_BRK       = 4;
  localparam int         B_FER       = 3;
  localparam int         B_PER       = 2;
  localparam int         B_OVR       = 1;
  localparam int         B_DR        = 0;
  localparam logic [7:0] STICKY_MASK = 8'hF3;
  localparam logic [7:0] FLAGS_RST   = 8'h60;
  localparam int         CNT_W       = 4;
  localparam logic [3:0] CNT_MAX     = 4'hF;

  // ----------------------------------------------------------------
  // Control, mode and baud
  // ----------------------------------------------------------------
  localparam int          B_RXEN     = 4;
  localparam int          B_PAR_EN   = 5;
  localparam int          B_PAR_ODD  = 4;
  localparam int          B_TWO_STOP = 3;
  localparam int          BAUD_W     = 16;
  localparam logic [15:0] BAUD_RST   = 16'h0364;
  localparam int          CHAR_BITS  = 8;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2
  } usr_rx_state_t;

  typedef struct packed {
    logic       parity_error_bit;
    logic       framing_error_bit;
    logic [7:0] data;
  } usr_entry_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } usr_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } usr_axi_rsp_t;

endpackage

// ### verif/usr_status_tb_top.sv
// Purpose: Self-checking bench for the serial receive status block.
// Assumes: Bit time of BIT_CLKS clocks set through the baud register.
// Notes:   Expected status words are built from the field layout.
module usr_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import usr_pkg::*;

  localparam int          BIT_CLKS = 8;
  localparam logic [31:0] RX_ON    = 32'h1 << B_RXEN;

  logic         clk;
  logic         rst;
  logic         rxd;
  logic         standby;
  logic         tx_end_evt;
  logic         tx_fifo_empty_evt;
  usr_axi_req_t req;
  usr_axi_rsp_t rsp;
  logic         cfg_par;
  logic         cfg_odd;
  int           bad_count;
  int           tests_run;

  usr_status i_usr_status (
    .clk               (clk),
    .rst               (rst),
    .rxd               (rxd),
    .standby           (standby),
    .tx_end_evt        (tx_end_evt),
    .tx_fifo_empty_evt (tx_fifo_empty_evt),
    .axi_req           (req),
    .axi_rsp           (rsp)
  );

  usr_tx_model i_usr_tx_model (
    .clk (clk),
    .rxd (rxd)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timed_out();
    bad_count++;
    $display("[FAIL] bus answer expected within 50 cycles seen none");
    end_of_test();
  endtask

  // ------------------------------------------------------------------
  // Bus cycles: payload held until its own ready is sampled high
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] addr, input logic [31:0] data,
                    input logic [1:0] resp);
    int n;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= addr;
    req.wvalid  <= 1'b1;
    req.wdata   <= data;
    req.bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
        break;
    end
    if (n == 50)
      timed_out();
    req.bready <= 1'b0;
    check("write response", {30'h0, resp}, {30'h0, rsp.bresp});
  endtask

  task automatic rd(input string what, input logic [7:0] addr,
                    input logic [31:0] exp, input logic [1:0] resp);
    int n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= addr;
    req.rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        break;
    end
    if (n == 50)
      timed_out();
    req.rready <= 1'b0;
    check(what, exp, rsp.rdata);
    check("read response", {30'h0, resp}, {30'h0, rsp.rresp});
  endtask

  task automatic st(input logic [15:0] exp);
    rd("status", OFF_STATUS, {16'h0, exp}, RESP_OKAY);
  endtask

  task automatic set_mode(input logic [7:0] m);
    wr(OFF_MODE, {24'h0, m}, RESP_OKAY);
    cfg_par = m[B_PAR_EN];
    cfg_odd = m[B_PAR_ODD];
  endtask

  // Waits past the synchroniser and push before status is read
  task automatic rx(input logic [7:0] d, input logic spoil,
                    input logic [1:0] stops);
    i_usr_tx_model.send(d, cfg_par, cfg_odd, spoil, stops);
    repeat (6) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  logic [7:0]  pop_d [4] = '{8'h55, 8'hA3, 8'h0F, 8'h01};
  logic [15:0] pop_s [4] = '{16'h11E5, 16'h01E9, 16'h00E1, 16'h00E1};

  initial
  begin
    rst = 1'b1;
    standby = 1'b0;
    tx_end_evt = 1'b0;
    tx_fifo_empty_evt = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    cfg_par = 1'b0;
    cfg_odd = 1'b0;
    bad_count = 0;
    tests_run = 0;
    i_usr_tx_model.bit_clks = BIT_CLKS;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr(OFF_STATUS, 32'h0000FFFF, RESP_OKAY);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    st(16'h0060);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    st(16'h0000);
    @(posedge clk);
    tx_end_evt <= 1'b1;
    tx_fifo_empty_evt <= 1'b1;
    @(posedge clk);
    tx_end_evt <= 1'b0;
    tx_fifo_empty_evt <= 1'b0;
    st(16'h0060);
    rd("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(OFF_BAUD, BIT_CLKS, RESP_OKAY);
    set_mode(8'h20);
    wr(OFF_CTRL, RX_ON, RESP_OKAY);
    rx(8'h55, 1'b0, 2'b11);
    st(16'h0061);
    rx(8'hA3, 1'b1, 2'b11);
    st(16'h10E1);
    rx(8'h0F, 1'b0, 2'b10);
    st(16'h11E1);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    st(16'h11E1);
    // A frame on the line while the receiver is off must leave no trace
    rx(8'h77, 1'b0, 2'b11);
    st(16'h11E1);
    set_mode(8'h38);
    wr(OFF_CTRL, RX_ON, RESP_OKAY);
    rx(8'h01, 1'b0, 2'b01);
    st(16'h11E1);
    for (int i = 0; i < 4; i++)
    begin
      rd("rx data", OFF_RXDATA, {24'h0, pop_d[i]}, RESP_OKAY);
      st(pop_s[i]);
    end
    rd("rx empty", OFF_RXDATA, 32'h0, RESP_OKAY);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    st(16'h0000);
    rx(8'h03, 1'b1, 2'b11);
    st(16'h1085);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    st(16'h1065);
    for (int i = 0; i < 16; i++)
      rx(8'h10 + i[7:0], 1'b0, 2'b11);
    st(16'h1067);
    rd("rx data", OFF_RXDATA, 32'h03, RESP_OKAY);
    for (int i = 0; i < 15; i++)
      rd("rx data", OFF_RXDATA, 32'h10 + i, RESP_OKAY);
    rd("rx empty", OFF_RXDATA, 32'h0, RESP_OKAY);
    st(16'h0063);
    // All-zero character with a low stop level: framing error plus break
    rx(8'h00, 1'b0, 2'b10);
    st(16'h01FB);
    end_of_test();
  end
endmodule

// ### verif/usr_tx_model.sv
// Purpose: Behavioural serial transmitter driving the receive line.
// Assumes: One bit lasts bit_clks rising edges of clk.
// Notes:   Line idles high, as a pulled-up receive line would.
module usr_tx_model (
  input  wire logic clk,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned bit_clks = 8;

  initial rxd = 1'b1;

  task automatic put_bit(input logic b);
    rxd <= b;
    repeat (bit_clks) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // One character; a spoiled parity or a low stop level is deliberate
  // ------------------------------------------------------------------
  task automatic send(
    input logic [7:0] data,
    input logic       par_en,
    input logic       odd,
    input logic       spoil,
    input logic [1:0] stops
  );
    @(posedge clk);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++)
      put_bit(data[i]);
    if (par_en)
      put_bit(^data ^ odd ^ spoil);
    put_bit(stops[0]);
    // Second stop period doubles as idle time in one-stop mode
    put_bit(stops[1]);
    rxd <= 1'b1;
  endtask
endmodule
